// ==== dv/mfsv_stat_counters.sv ====
// Purpose: Statistics counter logic that consumes the vectors.
// Assumes: Vectors are valid for one cycle.
// Notes: Counts sent frames and good received frames.
`timescale 1ns/1ps
`default_nettype none
module mfsv_stat_counters (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txStatValid,
  input wire logic rxStatValid,
  input wire logic [mfsv_pkg::RX_W-1:0] rxStatVec,
  output logic [15:0] txFrames,
  output logic [15:0] rxGood
);
  import mfsv_pkg::*;
  always_ff @(posedge clk) begin
    if (sys_rst) txFrames <= 16'h0000;
    else if (txStatValid) txFrames <= txFrames + 16'h0001;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) rxGood <= 16'h0000;
    else if (rxStatValid && rxStatVec[RXB_GOOD]) rxGood <= rxGood + 16'h0001;
  end
endmodule : mfsv_stat_counters
`default_nettype wire

// ==== dv/mfsv_stat_vectors_monitor.sv ====
// Purpose: Port checks on the statistics vector block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Vectors show two cycles after the last byte.
`timescale 1ns/1ps
`default_nettype none
module mfsv_stat_vectors_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txByteEn,
  input wire logic txLastByte,
  input wire logic txUnderrun,
  input wire logic txPauseSent,
  input wire logic rxByteEn,
  input wire logic rxLastByte,
  input wire logic rxChecksumBad,
  input wire logic rxLineErr,
  input wire logic promiscEn,
  input wire logic addrFilterPass,
  input wire logic [mfsv_pkg::TX_W-1:0] txStatVec,
  input wire logic txStatValid,
  input wire logic [mfsv_pkg::RX_W-1:0] rxStatVec,
  input wire logic rxStatValid
);
  import mfsv_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  tx_due_a: assert property (txByteEn && txLastByte |-> ##2 txStatValid) else $error("tx late");
  tx_cause_a: assert property (txStatValid |-> $past(txByteEn && txLastByte, 2)) else $error("tx stray");
  tx_hold_a: assert property (!txStatValid |-> $stable({txStatVec[31], txStatVec[29:0]}))
    else $error("tx moved");
  tx_zero_a: assert property (txStatVec[29:20] == 10'h000) else $error("tx zero");
  tx_pause_a: assert property (txStatValid |-> txStatVec[31] == $past(txPauseSent, 2))
    else $error("tx pause");
  tx_byte_bit_a: assert property (!$past(sys_rst) |-> txStatVec[30] == $past(txByteEn))
    else $error("tx byte");
  tx_under_a: assert property (txStatValid |-> txStatVec[3] != txStatVec[0] &&
    txStatVec[3] == $past(txUnderrun, 2)) else $error("tx under");
  rx_due_a: assert property (rxByteEn && rxLastByte |-> ##2 rxStatValid) else $error("rx late");
  rx_cause_a: assert property (rxStatValid |-> $past(rxByteEn && rxLastByte, 2)) else $error("rx stray");
  rx_hold_a: assert property (!rxStatValid |-> $stable({rxStatVec[27:23], rxStatVec[21:0]}))
    else $error("rx moved");
  rx_byte_bit_a: assert property (!$past(sys_rst) |-> rxStatVec[22] == $past(rxByteEn))
    else $error("rx byte");
  rx_addr_a: assert property (rxStatValid |-> rxStatVec[27] == $past(promiscEn || addrFilterPass, 2))
    else $error("rx addr");
  rx_fcs_a: assert property (rxStatValid |-> rxStatVec[2] == $past(rxChecksumBad || rxLineErr, 2))
    else $error("rx fcs");
  rx_good_bad_a: assert property (rxStatValid |-> rxStatVec[0] != rxStatVec[1]) else $error("rx good");
endmodule : mfsv_stat_vectors_monitor
bind mfsv_stat_vectors mfsv_stat_vectors_monitor u_mon (.clk, .sys_rst, .txByteEn, .txLastByte, .txUnderrun, .txPauseSent,
  .rxByteEn, .rxLastByte, .rxChecksumBad, .rxLineErr, .promiscEn, .addrFilterPass, .txStatVec, .txStatValid,
  .rxStatVec, .rxStatValid);
`default_nettype wire

// ==== dv/test_mac_frame_statistics_vectors.sv ====
// Purpose: Self-checking bench for the statistics vector block.
// Assumes: Same bytes go down both paths at once.
// Notes: Settings only change while both paths are idle.
`timescale 1ns/1ps
`default_nettype none
module test_mac_frame_statistics_vectors;
  import mfsv_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic txByteEn = 1'b0, txLastByte = 1'b0, txUnderrun = 1'b0, txPauseSent = 1'b0, txVlanEn = 1'b0;
  logic rxByteEn = 1'b0, rxLastByte = 1'b0, rxChecksumBad = 1'b0, rxLineErr = 1'b0, rxNibbleSkew = 1'b0;
  logic nibbleMode = 1'b0, rxVlanEn = 1'b0, jumboEn = 1'b0, lenCheckEn = 1'b0;
  logic promiscEn = 1'b0, addrFilterPass = 1'b0, rxFlowEn = 1'b0, txStatValid, rxStatValid;
  logic [7:0] txByte = 8'h00, rxByte = 8'h00;
  logic [47:0] macAddr = 48'h0200_1234_5678, da;
  logic [TX_W-1:0] txStatVec, txq[$];
  logic [RX_W-1:0] rxStatVec, rxq[$];
  logic [15:0] txFrames, rxGood, lt, op;
  logic [31:0] seed = 32'hC4BC0E40, r;
  logic [5:0] cfg = 6'h00;
  int n_fail = 0, compares = 0, sent = 0, goods = 0, n;
  int lens[8] = '{60, 64, 65, 100, 1518, 1519, 1522, 1523};
  always #20 clk = ~clk;
  mfsv_stat_vectors u_dut (.clk, .sys_rst, .txByteEn, .txByte, .txLastByte, .txUnderrun, .txPauseSent, .txVlanEn,
    .rxByteEn, .rxByte, .rxLastByte, .rxChecksumBad, .rxLineErr, .rxNibbleSkew, .nibbleMode, .rxVlanEn, .jumboEn,
    .lenCheckEn, .promiscEn, .addrFilterPass, .rxFlowEn, .macAddr, .txStatVec, .txStatValid, .rxStatVec, .rxStatValid);
  mfsv_stat_counters u_cnt (.clk, .sys_rst, .txStatValid, .rxStatValid, .rxStatVec, .txFrames, .rxGood);
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic idle(input int k);
    repeat (k) begin
      @(posedge clk);
      {txByteEn, rxByteEn, txLastByte, rxLastByte} <= 4'h0;
    end
  endtask : idle
  // Flag bits f: underrun, pause, bad checksum, line error, skew, promiscuous, filter pass.
  task automatic frame(input int n, input logic [47:0] da, input logic [15:0] lt, input logic [15:0] op,
    input logic [6:0] f);
    logic bc, mc, tg, ct, sk, le, ov, bad;
    logic [13:0] ln;
    logic [7:0] b;
    bc = da == DA_BCAST;
    mc = da[40] & !bc;
    tg = lt == TYPE_VLAN;
    ct = lt == TYPE_CTRL;
    ln = (n > 16383) ? 14'h3FFF : 14'(n);
    sk = cfg[0] & f[4] & f[2];
    le = cfg[3] && lt <= LEN_FIELD_LIMIT && n >= 64 && ((lt < 46) ? n != 64 : int'(lt) != n - 18);
    ov = !cfg[2] && n > ((tg && cfg[1]) ? 1522 : 1518);
    bad = f[2] | f[3] | sk | ov | le | (n < 64);
    sent++;
    goods += int'(!bad);
    txq.push_back({f[1], 1'b0, 10'h000, tg & cfg[5], ln, ct, f[0], mc, bc, !f[0]});
    rxq.push_back({f[5] | f[6], sk, le, !bad & ct & (op != OP_PAUSE),
      !bad & ct & (op == OP_PAUSE) & (da == DA_CTRL || da == macAddr) & cfg[4], 1'b0, tg & cfg[1], ov, ct, ln, mc, bc,
      f[2] | f[3], bad, !bad});
    for (int i = 0; i < n; i++) begin
      b = (i < 6) ? da[47 - 8 * i -: 8] : (i == 12) ? lt[15:8] : (i == 13) ? lt[7:0] : (i == 14) ? op[15:8] : op[7:0];
      if (i > 15 || (i > 5 && i < 12)) b = 8'(xs());
      @(posedge clk);
      {txByteEn, rxByteEn, txByte, rxByte} <= {2'b11, b, b};
      {txLastByte, rxLastByte} <= {2{i == n - 1}};
      {addrFilterPass, promiscEn, rxNibbleSkew, rxLineErr, rxChecksumBad, txPauseSent, txUnderrun} <= f;
    end
  endtask : frame
  always @(posedge clk) begin
    if (txStatValid === 1'b1) begin
      if (txq.size() == 0) chk(32'h1, 32'h0);
      else chk(txStatVec & 32'hBFFF_FFFF, txq.pop_front());
    end
    if (rxStatValid === 1'b1) begin
      if (rxq.size() == 0) chk(32'h1, 32'h0);
      else chk(32'(rxStatVec & 28'hFBF_FFFF), 32'(rxq.pop_front()));
    end
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 40; k++) begin
      r = xs();
      if (r[8] || k == 0) begin
        idle(3);
        cfg = 6'(r >> 26);
        {txVlanEn, rxFlowEn, lenCheckEn, jumboEn, rxVlanEn, nibbleMode} <= cfg;
      end
      n = lens[r[7:5]];
      da = (r[1:0] == 2'd0) ? DA_BCAST : (r[1:0] == 2'd1) ? DA_CTRL : (r[1:0] == 2'd2) ? macAddr : {xs(), 16'(xs())};
      lt = (r[3:2] == 2'd0) ? TYPE_CTRL : (r[3:2] == 2'd1) ? TYPE_VLAN : (r[3:2] == 2'd2) ? 16'(n - 18) : {5'h00, r[26:16]};
      op = r[4] ? OP_PAUSE : {8'h00, r[15:8]};
      frame(n, da, lt, op, 7'(r >> 9));
    end
    frame(16400, DA_BCAST, TYPE_VLAN, OP_PAUSE, 7'h00);
    idle(6);
    chk(32'(txq.size() + rxq.size()), 32'h0);
    chk({16'h0000, txFrames}, 32'(sent));
    chk({16'h0000, rxGood}, 32'(goods));
    complete_run();
  end
endmodule : test_mac_frame_statistics_vectors
`default_nettype wire

// ==== shared/mfsv_parse_if.sv ====
// Purpose: Carries one byte stream into a frame parser and its results out.
// Assumes: Stream and results share the block clock.
// Notes: Results stay put from the done pulse until the next frame starts.
`timescale 1ns/1ps
`default_nettype none
interface mfsv_parse_if;
  import mfsv_pkg::*;
  logic byteEn;
  logic [7:0] byteData;
  logic lastByte;
  logic done;
  logic [CNT_W-1:0] frameLen;
  logic [47:0] destAddr;
  logic [15:0] lenType;
  logic [15:0] opcode;
  modport parser (
    input byteEn, byteData, lastByte,
    output done, frameLen, destAddr, lenType, opcode
  );
  modport user (
    output byteEn, byteData, lastByte,
    input done, frameLen, destAddr, lenType, opcode
  );
endinterface : mfsv_parse_if
`default_nettype wire

// ==== shared/mfsv_pkg.sv ====
// Purpose: Shared constants for the per-frame statistics vector block.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes: Bit positions follow the transmit and receive vector layouts.
`default_nettype none
package mfsv_pkg;
  localparam int TX_W = 32;
  localparam int RX_W = 28;
  localparam int LEN_W = 14;
  localparam int CNT_W = 15;
  // Transmit vector bit positions.
  localparam int TXB_PAUSE = 31;
  localparam int TXB_BYTE = 30;
  localparam int TXB_VLAN = 19;
  localparam int TXB_LEN_HI = 18;
  localparam int TXB_LEN_LO = 5;
  localparam int TXB_CTRL = 4;
  localparam int TXB_UNDER = 3;
  localparam int TXB_MCAST = 2;
  localparam int TXB_BCAST = 1;
  localparam int TXB_GOOD = 0;
  // Receive vector bit positions.
  localparam int RXB_ADDR = 27;
  localparam int RXB_SKEW = 26;
  localparam int RXB_LENERR = 25;
  localparam int RXB_BADOP = 24;
  localparam int RXB_FLOW = 23;
  localparam int RXB_BYTE = 22;
  localparam int RXB_VLAN = 21;
  localparam int RXB_OVER = 20;
  localparam int RXB_CTRL = 19;
  localparam int RXB_LEN_HI = 18;
  localparam int RXB_LEN_LO = 5;
  localparam int RXB_MCAST = 4;
  localparam int RXB_BCAST = 3;
  localparam int RXB_FCS = 2;
  localparam int RXB_BAD = 1;
  localparam int RXB_GOOD = 0;
  // Reset values of the vectors.
  localparam logic [TX_W-1:0] TX_RST = 32'h0000_0000;
  localparam logic [RX_W-1:0] RX_RST = 28'h000_0000;
  // Length counters stick at the first two counts; the transmit length field clamps at the third.
  localparam logic [CNT_W-1:0] TX_LEN_SAT = 15'h41C6;
  localparam logic [CNT_W-1:0] RX_LEN_SAT = 15'h3FFF;
  localparam logic [CNT_W-1:0] LEN_FIELD_MAX = 15'h3FFF;
  // Frame field values and positions.
  localparam logic [15:0] TYPE_CTRL = 16'h8808;
  localparam logic [15:0] TYPE_VLAN = 16'h8100;
  localparam logic [15:0] OP_PAUSE = 16'h0001;
  localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05DC;
  localparam logic [47:0] DA_CTRL = 48'h0180_C200_0001;
  localparam logic [47:0] DA_BCAST = 48'hFFFF_FFFF_FFFF;
  localparam logic [CNT_W-1:0] DA_BYTES = 15'h0006;
  localparam logic [CNT_W-1:0] LT_POS = 15'h000C;
  localparam logic [CNT_W-1:0] OP_END = 15'h0010;
  localparam logic [CNT_W-1:0] HDR_FCS = 15'h0012;
  localparam logic [CNT_W-1:0] MIN_FRAME = 15'h0040;
  localparam logic [CNT_W-1:0] MIN_DATA = 15'h002E;
  localparam logic [CNT_W-1:0] MAX_STD = 15'h05EE;
  localparam logic [CNT_W-1:0] MAX_TAGGED = 15'h05F2;
endpackage : mfsv_pkg
`default_nettype wire

// ==== src/mfsv_frame_parse.sv ====
// Purpose: Counts the bytes of a frame and captures its header fields.
// Assumes: One byte per enabled cycle, destination address first.
// Notes: The byte count sticks at SAT instead of wrapping.
`timescale 1ns/1ps
`default_nettype none
module mfsv_frame_parse #(
  parameter logic [14:0] SAT = 15'h3FFF
) (
  input wire logic clk,
  input wire logic sys_rst,
  mfsv_parse_if.parser pif
);
  import mfsv_pkg::*;

  logic inFrame_r;
  logic done_r;
  logic [CNT_W-1:0] cnt_r;
  logic [47:0] da_r;
  logic [31:0] ltOp_r;
  logic [CNT_W-1:0] idx;

  // Position of the byte now on the stream, zero at a frame start.
  assign idx = inFrame_r ? cnt_r : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inFrame_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= pif.byteEn & pif.lastByte;
      if (pif.byteEn) begin
        inFrame_r <= ~pif.lastByte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else if (pif.byteEn) begin
      if (!inFrame_r) begin
        cnt_r <= 15'h0001;
      end else if (cnt_r < SAT) begin
        cnt_r <= cnt_r + 15'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      da_r <= '0;
      ltOp_r <= '0;
    end else if (pif.byteEn) begin
      if (idx < DA_BYTES) begin
        da_r <= {da_r[39:0], pif.byteData};
      end
      if (idx >= LT_POS && idx < OP_END) begin
        ltOp_r <= {ltOp_r[23:0], pif.byteData};
      end
    end
  end

  assign pif.done = done_r;
  assign pif.frameLen = cnt_r;
  assign pif.destAddr = da_r;
  assign pif.lenType = ltOp_r[31:16];
  assign pif.opcode = ltOp_r[15:0];
endmodule : mfsv_frame_parse
`default_nettype wire

// ==== src/mfsv_stat_vectors.sv ====
// Purpose: Builds one transmit and one receive statistics vector per frame.
// Assumes: MAC byte streams and error flags come from logic on clk.
// Notes: Vectors show two cycles after the last byte, for one cycle.
`timescale 1ns/1ps
`default_nettype none
module mfsv_stat_vectors (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic txByteEn,
  input wire logic [7:0] txByte,
  input wire logic txLastByte,
  input wire logic txUnderrun,
  input wire logic txPauseSent,
  input wire logic txVlanEn,
  input wire logic rxByteEn,
  input wire logic [7:0] rxByte,
  input wire logic rxLastByte,
  input wire logic rxChecksumBad,
  input wire logic rxLineErr,
  input wire logic rxNibbleSkew,
  input wire logic nibbleMode,
  input wire logic rxVlanEn,
  input wire logic jumboEn,
  input wire logic lenCheckEn,
  input wire logic promiscEn,
  input wire logic addrFilterPass,
  input wire logic rxFlowEn,
  input wire logic [47:0] macAddr,
  output logic [mfsv_pkg::TX_W-1:0] txStatVec,
  output logic txStatValid,
  output logic [mfsv_pkg::RX_W-1:0] rxStatVec,
  output logic rxStatValid
);
  import mfsv_pkg::*;

  mfsv_parse_if txPif ();
  mfsv_parse_if rxPif ();

  assign txPif.byteEn = txByteEn;
  assign txPif.byteData = txByte;
  assign txPif.lastByte = txLastByte;
  assign rxPif.byteEn = rxByteEn;
  assign rxPif.byteData = rxByte;
  assign rxPif.lastByte = rxLastByte;

  mfsv_frame_parse #(
    .SAT(TX_LEN_SAT)
  ) txParse (
    .clk(clk),
    .sys_rst(sys_rst),
    .pif(txPif.parser)
  );

  mfsv_frame_parse #(
    .SAT(RX_LEN_SAT)
  ) rxParse (
    .clk(clk),
    .sys_rst(sys_rst),
    .pif(rxPif.parser)
  );

  // Per-frame flags from the MAC are only meaningful with the last byte,
  // so they are held here until the parser reports the frame complete.
  logic txUnderrun_r;
  logic txPauseSent_r;
  logic txVlanEn_r;
  logic rxChecksumBad_r;
  logic rxLineErr_r;
  logic rxNibbleSkew_r;
  logic rxAddrOk_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txUnderrun_r <= 1'b0;
      txPauseSent_r <= 1'b0;
      txVlanEn_r <= 1'b0;
    end else if (txByteEn && txLastByte) begin
      txUnderrun_r <= txUnderrun;
      txPauseSent_r <= txPauseSent;
      txVlanEn_r <= txVlanEn;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxChecksumBad_r <= 1'b0;
      rxLineErr_r <= 1'b0;
      rxNibbleSkew_r <= 1'b0;
      rxAddrOk_r <= 1'b0;
    end else if (rxByteEn && rxLastByte) begin
      rxChecksumBad_r <= rxChecksumBad;
      rxLineErr_r <= rxLineErr;
      rxNibbleSkew_r <= rxNibbleSkew;
      rxAddrOk_r <= promiscEn | addrFilterPass;
    end
  end

  // Transmit frame classification.
  logic [LEN_W-1:0] txLenField;
  logic txIsCtrl;
  logic txIsTagged;
  logic txIsMcast;
  logic txIsBcast;

  always_comb begin
    // The counter may stick above what 14 bits can show; clamp it there.
    if (txPif.frameLen > LEN_FIELD_MAX) begin
      txLenField = LEN_FIELD_MAX[LEN_W-1:0];
    end else begin
      txLenField = txPif.frameLen[LEN_W-1:0];
    end
  end

  assign txIsCtrl = (txPif.lenType == TYPE_CTRL);
  assign txIsTagged = (txPif.lenType == TYPE_VLAN) & txVlanEn_r;
  assign txIsBcast = (txPif.destAddr == DA_BCAST);
  assign txIsMcast = txPif.destAddr[40] & ~txIsBcast;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txStatValid <= 1'b0;
    end else begin
      txStatValid <= txPif.done;
    end
  end

  // Bit 30 and the per-frame fields each have a register of their own, so
  // that every bit of the port has exactly one process behind it.
  logic txByteBit_r;
  logic txPauseBit_r;
  logic txTagBit_r;
  logic [LEN_W-1:0] txLen_r;
  logic txCtrlBit_r;
  logic txUnderBit_r;
  logic txMcastBit_r;
  logic txBcastBit_r;
  logic txGoodBit_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txByteBit_r <= TX_RST[TXB_BYTE];
    end else begin
      txByteBit_r <= txByteEn;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txPauseBit_r <= TX_RST[TXB_PAUSE];
      txTagBit_r <= TX_RST[TXB_VLAN];
      txLen_r <= TX_RST[TXB_LEN_HI:TXB_LEN_LO];
      txCtrlBit_r <= TX_RST[TXB_CTRL];
      txUnderBit_r <= TX_RST[TXB_UNDER];
      txMcastBit_r <= TX_RST[TXB_MCAST];
      txBcastBit_r <= TX_RST[TXB_BCAST];
      txGoodBit_r <= TX_RST[TXB_GOOD];
    end else if (txPif.done) begin
      txPauseBit_r <= txPauseSent_r;
      txTagBit_r <= txIsTagged;
      txLen_r <= txLenField;
      txCtrlBit_r <= txIsCtrl;
      txUnderBit_r <= txUnderrun_r;
      txMcastBit_r <= txIsMcast;
      txBcastBit_r <= txIsBcast;
      // Without half duplex, an underrun is the only way a send can fail.
      txGoodBit_r <= ~txUnderrun_r;
    end
  end

  // Wiring only: bits not named here, the half-duplex and reserved ones, stay zero.
  always_comb begin
    txStatVec = '0;
    txStatVec[TXB_PAUSE] = txPauseBit_r;
    txStatVec[TXB_BYTE] = txByteBit_r;
    txStatVec[TXB_VLAN] = txTagBit_r;
    txStatVec[TXB_LEN_HI:TXB_LEN_LO] = txLen_r;
    txStatVec[TXB_CTRL] = txCtrlBit_r;
    txStatVec[TXB_UNDER] = txUnderBit_r;
    txStatVec[TXB_MCAST] = txMcastBit_r;
    txStatVec[TXB_BCAST] = txBcastBit_r;
    txStatVec[TXB_GOOD] = txGoodBit_r;
  end

  // Receive frame classification.
  logic [LEN_W-1:0] rxLenField;
  logic [CNT_W-1:0] rxDataBytes;
  logic [CNT_W-1:0] rxLenValue;
  logic rxIsCtrl;
  logic rxIsPause;
  logic rxIsTagged;
  logic rxIsMcast;
  logic rxIsBcast;
  logic rxIsLength;
  logic rxIsRunt;
  logic rxLenErr;
  logic rxOversize;
  logic rxSkew;
  logic rxCodeOrCrc;
  logic rxBad;
  logic rxPauseDest;

  assign rxLenField = rxPif.frameLen[LEN_W-1:0];
  assign rxIsCtrl = (rxPif.lenType == TYPE_CTRL);
  assign rxIsPause = rxIsCtrl & (rxPif.opcode == OP_PAUSE);
  assign rxIsTagged = (rxPif.lenType == TYPE_VLAN) & rxVlanEn;
  assign rxIsBcast = (rxPif.destAddr == DA_BCAST);
  assign rxIsMcast = rxPif.destAddr[40] & ~rxIsBcast;
  assign rxIsLength = (rxPif.lenType <= LEN_FIELD_LIMIT);
  assign rxIsRunt = (rxPif.frameLen < MIN_FRAME);
  assign rxLenValue = {3'b000, rxPif.lenType[11:0]};
  assign rxPauseDest = (rxPif.destAddr == DA_CTRL) |
                       (rxPif.destAddr == macAddr);

  always_comb begin
    if (rxPif.frameLen > HDR_FCS) begin
      rxDataBytes = rxPif.frameLen - HDR_FCS;
    end else begin
      rxDataBytes = '0;
    end
  end

  always_comb begin
    // A short length means padding, so the frame must be minimum size.
    rxLenErr = 1'b0;
    if (lenCheckEn && rxIsLength && !rxIsRunt) begin
      if (rxLenValue < MIN_DATA) begin
        rxLenErr = (rxPif.frameLen != MIN_FRAME);
      end else begin
        rxLenErr = (rxLenValue != rxDataBytes);
      end
    end
  end

  always_comb begin
    rxOversize = 1'b0;
    if (!jumboEn) begin
      if (rxIsTagged) begin
        rxOversize = (rxPif.frameLen > MAX_TAGGED);
      end else begin
        rxOversize = (rxPif.frameLen > MAX_STD);
      end
    end
  end

  assign rxCodeOrCrc = rxChecksumBad_r | rxLineErr_r;
  assign rxSkew = nibbleMode & rxNibbleSkew_r & rxChecksumBad_r;
  // A length mismatch only spoils the frame while the check is on.
  assign rxBad = rxCodeOrCrc | rxSkew | rxOversize | rxLenErr | rxIsRunt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxStatValid <= 1'b0;
    end else begin
      rxStatValid <= rxPif.done;
    end
  end

  // As on the transmit side, one register per field and a wired-up port.
  logic rxByteBit_r;
  logic rxAddrBit_r;
  logic rxSkewBit_r;
  logic rxLenErrBit_r;
  logic rxBadOpBit_r;
  logic rxFlowBit_r;
  logic rxTagBit_r;
  logic rxOverBit_r;
  logic rxCtrlBit_r;
  logic [LEN_W-1:0] rxLen_r;
  logic rxMcastBit_r;
  logic rxBcastBit_r;
  logic rxFcsBit_r;
  logic rxBadBit_r;
  logic rxGoodBit_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxByteBit_r <= RX_RST[RXB_BYTE];
    end else begin
      rxByteBit_r <= rxByteEn;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxAddrBit_r <= RX_RST[RXB_ADDR];
      rxSkewBit_r <= RX_RST[RXB_SKEW];
      rxLenErrBit_r <= RX_RST[RXB_LENERR];
      rxBadOpBit_r <= RX_RST[RXB_BADOP];
      rxFlowBit_r <= RX_RST[RXB_FLOW];
      rxTagBit_r <= RX_RST[RXB_VLAN];
      rxOverBit_r <= RX_RST[RXB_OVER];
      rxCtrlBit_r <= RX_RST[RXB_CTRL];
      rxLen_r <= RX_RST[RXB_LEN_HI:RXB_LEN_LO];
      rxMcastBit_r <= RX_RST[RXB_MCAST];
      rxBcastBit_r <= RX_RST[RXB_BCAST];
      rxFcsBit_r <= RX_RST[RXB_FCS];
      rxBadBit_r <= RX_RST[RXB_BAD];
      rxGoodBit_r <= RX_RST[RXB_GOOD];
    end else if (rxPif.done) begin
      rxAddrBit_r <= rxAddrOk_r;
      rxSkewBit_r <= rxSkew;
      rxLenErrBit_r <= rxLenErr;
      rxBadOpBit_r <= ~rxBad & rxIsCtrl & ~rxIsPause;
      rxFlowBit_r <= ~rxBad & rxIsPause & rxPauseDest & rxFlowEn;
      rxTagBit_r <= rxIsTagged;
      rxOverBit_r <= rxOversize;
      rxCtrlBit_r <= rxIsCtrl;
      rxLen_r <= rxLenField;
      rxMcastBit_r <= rxIsMcast;
      rxBcastBit_r <= rxIsBcast;
      rxFcsBit_r <= rxCodeOrCrc;
      rxBadBit_r <= rxBad;
      rxGoodBit_r <= ~rxBad;
    end
  end

  always_comb begin
    rxStatVec = '0;
    rxStatVec[RXB_ADDR] = rxAddrBit_r;
    rxStatVec[RXB_SKEW] = rxSkewBit_r;
    rxStatVec[RXB_LENERR] = rxLenErrBit_r;
    rxStatVec[RXB_BADOP] = rxBadOpBit_r;
    rxStatVec[RXB_FLOW] = rxFlowBit_r;
    rxStatVec[RXB_BYTE] = rxByteBit_r;
    rxStatVec[RXB_VLAN] = rxTagBit_r;
    rxStatVec[RXB_OVER] = rxOverBit_r;
    rxStatVec[RXB_CTRL] = rxCtrlBit_r;
    rxStatVec[RXB_LEN_HI:RXB_LEN_LO] = rxLen_r;
    rxStatVec[RXB_MCAST] = rxMcastBit_r;
    rxStatVec[RXB_BCAST] = rxBcastBit_r;
    rxStatVec[RXB_FCS] = rxFcsBit_r;
    rxStatVec[RXB_BAD] = rxBadBit_r;
    rxStatVec[RXB_GOOD] = rxGoodBit_r;
  end
endmodule : mfsv_stat_vectors
`default_nettype wire
